// file: logic/aid_pkg.sv
// package for the arithmetic instruction decoder
// assumes a single 25 MHz core clock, registers reached over avalon-mm
package aid_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] PRIMARY_OPERAND_REG_OFS = 8'hE0;
    localparam logic [7:0] PROGRAM_FLAGS_WORD_OFS = 8'hD0;
    localparam logic [7:0] SECONDARY_OPERAND_REG_OFS = 8'hF0;
    localparam logic [7:0] INSTR_CTRL_OFS = 8'h00;
    localparam logic [7:0] INSTR_STAT_OFS = 8'h04;
    localparam logic [7:0] OPERAND_DATA_OFS = 8'h08;
    localparam logic [7:0] BYTE_TWO_OFS = 8'h0C;
    localparam logic [7:0] DECODE_INFO_OFS = 8'h10;
    localparam logic [7:0] BANK_REGS_OFS = 8'h20;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] PRIMARY_OPERAND_REG_RST = 8'h00;
    localparam logic [7:0] PROGRAM_FLAGS_WORD_RST = 8'h00;
    localparam logic [7:0] SECONDARY_OPERAND_REG_RST = 8'h00;
    // ****************************************
    // flag word bit positions
    // ****************************************
    localparam int FLAG_CY = 7;
    localparam int FLAG_AC = 6;
    localparam int FLAG_OV = 2;
    localparam int FLAG_P = 0;
    localparam int FLAG_RS_LO = 3;
    // ****************************************
    // opcodes and families
    // ****************************************
    localparam logic [3:0] FAM_ADD = 4'h2;
    localparam logic [3:0] FAM_ADD_WITH_CARRY = 4'h3;
    localparam logic [3:0] FAM_SUBTRACT_WITH_BORROW = 4'h9;
    localparam logic [3:0] LO_IMM = 4'h4;
    localparam logic [3:0] LO_DIR = 4'h5;
    localparam logic [7:0] OPC_MUL = 8'hA4;
    localparam logic [7:0] OPC_DIV = 8'h84;
    // ****************************************
    // timing
    // ****************************************
    localparam int OSC_PER_MC = 12;
    localparam int CLK_HZ = 25000000;
    localparam int OSC_HZ = 12000000;
    localparam int MC_SHORT = 1;
    localparam int MC_LONG = 4;
    localparam int INSTR_ONE_BYTE = 49;
    localparam int INSTR_TWO_BYTE = 46;
    localparam int INSTR_THREE_BYTE = 16;
    // machine cycle in core clocks: 12 osc periods, rounded down, >= 1
    localparam int MC_CLKS_RAW = (OSC_PER_MC * CLK_HZ) / OSC_HZ;
    localparam int MC_CLKS = (MC_CLKS_RAW < 1) ? 1 : MC_CLKS_RAW;
    // ****************************************
    // operations
    // ****************************************
    typedef enum logic [2:0] {
        AID_OP_NONE = 3'h0,
        AID_OP_ADD = 3'h1,
        AID_OP_ADD_WITH_CARRY = 3'h2,
        AID_OP_SUBTRACT_WITH_BORROW = 3'h3,
        AID_OP_MUL = 3'h4,
        AID_OP_DIV = 3'h5
    } aid_op_t;
    typedef enum logic [1:0] {
        AID_SRC_REG = 2'h0,
        AID_SRC_DIR = 2'h1,
        AID_SRC_IND = 2'h2,
        AID_SRC_IMM = 2'h3
    } aid_src_t;
endpackage

// file: logic/aid_decode.sv
// combinational opcode decoder for the arithmetic group
// assumes the opcode byte is held stable by the caller
`timescale 1ns/100ps
module aid_decode (
    input wire logic [7:0] opcode,
    output aid_pkg::aid_op_t op,
    output aid_pkg::aid_src_t src,
    output logic [1:0] length,
    output logic [2:0] cycles,
    output logic [2:0] reg_sel,
    output logic valid
);
    logic [3:0] hi;
    logic [3:0] lo;
    assign hi = opcode[7:4];
    assign lo = opcode[3:0];
    always_comb begin
        op = aid_pkg::AID_OP_NONE;
        src = aid_pkg::AID_SRC_REG;
        length = 2'd1;
        cycles = 3'(aid_pkg::MC_SHORT);
        reg_sel = opcode[2:0];
        valid = 1'b0;
        if (opcode == aid_pkg::OPC_MUL) begin
            op = aid_pkg::AID_OP_MUL;
            cycles = 3'(aid_pkg::MC_LONG);
            valid = 1'b1;
        end else if (opcode == aid_pkg::OPC_DIV) begin
            op = aid_pkg::AID_OP_DIV;
            cycles = 3'(aid_pkg::MC_LONG);
            valid = 1'b1;
        end else if ((hi == aid_pkg::FAM_ADD || hi == aid_pkg::FAM_ADD_WITH_CARRY
                || hi == aid_pkg::FAM_SUBTRACT_WITH_BORROW) && lo >= aid_pkg::LO_IMM) begin
            valid = 1'b1;
            if (hi == aid_pkg::FAM_ADD) begin
                op = aid_pkg::AID_OP_ADD;
            end else if (hi == aid_pkg::FAM_ADD_WITH_CARRY) begin
                op = aid_pkg::AID_OP_ADD_WITH_CARRY;
            end else begin
                op = aid_pkg::AID_OP_SUBTRACT_WITH_BORROW;
            end
            if (lo[3]) begin
                src = aid_pkg::AID_SRC_REG;
            end else if (lo == aid_pkg::LO_IMM) begin
                src = aid_pkg::AID_SRC_IMM;
                length = 2'd2;
            end else if (lo == aid_pkg::LO_DIR) begin
                src = aid_pkg::AID_SRC_DIR;
                length = 2'd2;
            end else begin
                src = aid_pkg::AID_SRC_IND;
                reg_sel = {2'b00, opcode[0]};
            end
        end
    end
endmodule // aid_decode

// file: logic/aid_core.sv
// arithmetic instruction decode and execute unit with avalon-mm registers
// assumes one 25 MHz clock and a synchronous active-low reset
// Contract
// - decoder handles one and two byte instructions only (length 1 or 2); set is 49/46/16.
// - machine cycle is twelve oscillator periods; short ops take one.
// - add family 2x: reg 28-2F, direct 25, indirect 26/27, immediate 24.
// - add-with-carry family 3x adds operand plus carry into accumulator.
// - subtract-with-borrow family 9x subtracts operand and borrow.
// - direct and immediate forms are two bytes; register and indirect one.
// - multiply A4 and divide 84 are one byte, four machine cycles.
`timescale 1ns/100ps
module aid_core #(
    parameter int MC_CLKS = aid_pkg::MC_CLKS
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic busy,
    output logic [7:0] accumulator
);
    // ****************************************
    // state
    // ****************************************
    typedef enum logic [2:0] {
        AID_IDLE = 3'b001,
        AID_EXEC = 3'b010,
        AID_DONE = 3'b100
    } aid_state_t;
    aid_state_t state_q, state_d;
    logic [7:0] acc_q, acc_d;
    logic [7:0] psw_q, psw_d;
    logic [7:0] b_q, b_d;
    logic [7:0] opc_q, opc_d;
    logic [7:0] byte2_q, byte2_d;
    logic [7:0] opnd_q, opnd_d;
    logic [7:0] bank_q [0:31];
    logic [7:0] bank_d [0:31];
    logic [7:0] clk_cnt_q, clk_cnt_d;
    logic [2:0] mc_left_q, mc_left_d;
    logic illegal_q, illegal_d;
    logic [1:0] len_q, len_d;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    aid_pkg::aid_op_t dec_op;
    aid_pkg::aid_src_t dec_src;
    logic [1:0] dec_len;
    logic [2:0] dec_cyc;
    logic [2:0] dec_reg;
    logic dec_valid;
    aid_decode u_decode (
        .opcode(opc_q),
        .op(dec_op),
        .src(dec_src),
        .length(dec_len),
        .cycles(dec_cyc),
        .reg_sel(dec_reg),
        .valid(dec_valid)
    );
    function automatic logic [4:0] bank_idx(input logic [7:0] program_flags_word,
                                            input logic [2:0] r);
        bank_idx = {program_flags_word[aid_pkg::FLAG_RS_LO+1 -: 2], r};
    endfunction
    function automatic logic parity(input logic [7:0] v);
        parity = ^v;
    endfunction
    logic [7:0] operand;
    logic [8:0] sum9;
    logic [4:0] sum_lo;
    logic [15:0] prod;
    logic cin;
    logic [7:0] sel_reg;
    logic req;
    assign req = (read || write) && !ack_q;
    assign waitrequest = req;
    assign readdata = rdata_q;
    assign busy = (state_q != AID_IDLE);
    assign accumulator = acc_q;
    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        state_d = state_q;
        acc_d = acc_q;
        psw_d = psw_q;
        b_d = b_q;
        opc_d = opc_q;
        byte2_d = byte2_q;
        opnd_d = opnd_q;
        bank_d = bank_q;
        clk_cnt_d = clk_cnt_q;
        mc_left_d = mc_left_q;
        illegal_d = illegal_q;
        len_d = len_q;
        ack_d = 1'b0;
        rdata_d = rdata_q;
        sel_reg = bank_q[bank_idx(psw_q, dec_reg)];
        if (dec_src == aid_pkg::AID_SRC_IMM) begin
            operand = byte2_q;
        end else if (dec_src == aid_pkg::AID_SRC_REG) begin
            operand = sel_reg;
        end else begin
            // direct and indirect bytes are fetched by the outside core
            operand = opnd_q;
        end
        cin = (dec_op == aid_pkg::AID_OP_ADD) ? 1'b0 : psw_q[aid_pkg::FLAG_CY];
        if (dec_op == aid_pkg::AID_OP_SUBTRACT_WITH_BORROW) begin
            sum9 = {1'b0, acc_q} - {1'b0, operand} - {8'h00, cin};
            sum_lo = {1'b0, acc_q[3:0]} - {1'b0, operand[3:0]} - {4'h0, cin};
        end else begin
            sum9 = {1'b0, acc_q} + {1'b0, operand} + {8'h00, cin};
            sum_lo = {1'b0, acc_q[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
        end
        prod = acc_q * b_q;
        if (req && write) begin
            ack_d = 1'b1;
            if (address == aid_pkg::PRIMARY_OPERAND_REG_OFS) begin
                acc_d = writedata[7:0];
            end else if (address == aid_pkg::PROGRAM_FLAGS_WORD_OFS) begin
                psw_d = writedata[7:0];
            end else if (address == aid_pkg::SECONDARY_OPERAND_REG_OFS) begin
                b_d = writedata[7:0];
            end else if (address == aid_pkg::OPERAND_DATA_OFS) begin
                opnd_d = writedata[7:0];
            end else if (address == aid_pkg::BYTE_TWO_OFS) begin
                byte2_d = writedata[7:0];
            end else if (address[7:5] == aid_pkg::BANK_REGS_OFS[7:5]
                         && address[1:0] == 2'b00) begin
                bank_d[{2'b00, address[4:2]} + {psw_q[4:3], 3'b000}] =
                    writedata[7:0];
            end else if (address == aid_pkg::INSTR_CTRL_OFS
                         && state_q == AID_IDLE) begin
                opc_d = writedata[7:0];
                state_d = AID_EXEC;
                clk_cnt_d = 8'h00;
                mc_left_d = 3'd0;
            end
        end else if (req && read) begin
            ack_d = 1'b1;
            rdata_d = 32'h0000_0000;
            if (address == aid_pkg::PRIMARY_OPERAND_REG_OFS) begin
                rdata_d[7:0] = acc_q;
            end else if (address == aid_pkg::PROGRAM_FLAGS_WORD_OFS) begin
                rdata_d[7:0] = psw_q;
            end else if (address == aid_pkg::SECONDARY_OPERAND_REG_OFS) begin
                rdata_d[7:0] = b_q;
            end else if (address == aid_pkg::INSTR_CTRL_OFS) begin
                rdata_d[7:0] = opc_q;
            end else if (address == aid_pkg::INSTR_STAT_OFS) begin
                rdata_d[2:0] = {illegal_q, state_q == AID_DONE, busy};
            end else if (address == aid_pkg::OPERAND_DATA_OFS) begin
                rdata_d[7:0] = opnd_q;
            end else if (address == aid_pkg::BYTE_TWO_OFS) begin
                rdata_d[7:0] = byte2_q;
            end else if (address == aid_pkg::DECODE_INFO_OFS) begin
                // cycle count of the held opcode, not the live down-counter
                rdata_d[5:0] = {dec_cyc, 1'b0, len_q};
            end
        end
        case (state_q)
            AID_IDLE: begin
            end
            AID_EXEC: begin
                if (clk_cnt_q == 8'h00 && mc_left_q == 3'd0) begin
                    mc_left_d = dec_valid ? dec_cyc : 3'd1;
                    len_d = dec_len;
                    illegal_d = !dec_valid;
                    clk_cnt_d = 8'h01;
                end else if (clk_cnt_q == 8'(MC_CLKS)) begin
                    clk_cnt_d = 8'h01;
                    mc_left_d = mc_left_q - 3'd1;
                    if (mc_left_q == 3'd1) begin
                        state_d = AID_DONE;
                        if (dec_op == aid_pkg::AID_OP_MUL) begin
                            acc_d = prod[7:0];
                            b_d = prod[15:8];
                            psw_d[aid_pkg::FLAG_CY] = 1'b0;
                            psw_d[aid_pkg::FLAG_OV] = (prod[15:8] != 8'h00);
                        end else if (dec_op == aid_pkg::AID_OP_DIV) begin
                            psw_d[aid_pkg::FLAG_CY] = 1'b0;
                            psw_d[aid_pkg::FLAG_OV] = (b_q == 8'h00);
                            if (b_q != 8'h00) begin
                                acc_d = acc_q / b_q;
                                b_d = acc_q % b_q;
                            end
                        end else if (dec_op != aid_pkg::AID_OP_NONE) begin
                            acc_d = sum9[7:0];
                            psw_d[aid_pkg::FLAG_CY] = sum9[8];
                            psw_d[aid_pkg::FLAG_AC] = sum_lo[4];
                            if (dec_op == aid_pkg::AID_OP_SUBTRACT_WITH_BORROW) begin
                                psw_d[aid_pkg::FLAG_OV] =
                                    (acc_q[7] != operand[7])
                                    && (sum9[7] != acc_q[7]);
                            end else begin
                                psw_d[aid_pkg::FLAG_OV] =
                                    (acc_q[7] == operand[7])
                                    && (sum9[7] != acc_q[7]);
                            end
                        end
                    end
                end else begin
                    clk_cnt_d = clk_cnt_q + 8'h01;
                end
            end
            AID_DONE: begin
                state_d = AID_IDLE;
            end
            default: begin
                state_d = AID_IDLE;
            end
        endcase
        psw_d[aid_pkg::FLAG_P] = parity(acc_d);
    end
    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_q <= AID_IDLE;
            acc_q <= aid_pkg::PRIMARY_OPERAND_REG_RST;
            psw_q <= aid_pkg::PROGRAM_FLAGS_WORD_RST;
            b_q <= aid_pkg::SECONDARY_OPERAND_REG_RST;
            opc_q <= 8'h00;
            byte2_q <= 8'h00;
            opnd_q <= 8'h00;
            clk_cnt_q <= 8'h00;
            mc_left_q <= 3'd0;
            illegal_q <= 1'b0;
            len_q <= 2'd0;
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            acc_q <= acc_d;
            psw_q <= psw_d;
            b_q <= b_d;
            opc_q <= opc_d;
            byte2_q <= byte2_d;
            opnd_q <= opnd_d;
            clk_cnt_q <= clk_cnt_d;
            mc_left_q <= mc_left_d;
            illegal_q <= illegal_d;
            len_q <= len_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end
    // bank registers are data, not reset
    always_ff @(posedge clock) begin
        bank_q <= bank_d;
    end
endmodule // aid_core

// file: testbench/aid_core_properties.sv
// assertions on the arithmetic unit's bus answers and timing
// assumes MC_CLKS of 2 or more and bind from the bench top
`timescale 1ns/100ps
module aid_core_properties #(
    parameter int MC_CLKS = 2
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic busy,
    input wire logic [7:0] accumulator
);
    logic [7:0] len_q, len_d;
    logic long_q, long_d, start;
    assign start = write && waitrequest && !busy
        && address == aid_pkg::INSTR_CTRL_OFS;
    // busy run length and kind of the running instruction
    always_comb begin
        len_d = busy ? len_q + 8'h01 : 8'h00;
        long_d = long_q;
        if (start) begin
            long_d = writedata[7:0] == aid_pkg::OPC_MUL
                || writedata[7:0] == aid_pkg::OPC_DIV;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            len_q <= 8'h00;
            long_q <= 1'b0;
        end else begin
            len_q <= len_d;
            long_q <= long_d;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_wait_one_state: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("bus not answered after one wait state");
    a_start_sets_busy: assert property (
        start |=> busy [*4]) else $error("busy not held after start");
    a_short_op_len: assert property (
        $fell(busy) && !long_q |-> len_q == 8'(2 + MC_CLKS))
        else $error("short instruction length wrong");
    a_long_op_len: assert property (
        $fell(busy) && long_q |-> len_q == 8'(2 + 4 * MC_CLKS))
        else $error("multiply or divide length wrong");
    a_acc_idle_hold: assert property (
        !busy && !(write && waitrequest) |=> $stable(accumulator))
        else $error("accumulator moved while idle");
    a_read_upper_zero: assert property (
        read && !waitrequest |-> readdata[31:8] == 24'h000000)
        else $error("read upper bits not zero");
    a_acc_readback: assert property (
        read && !waitrequest && !busy
        && address == aid_pkg::PRIMARY_OPERAND_REG_OFS
        |-> readdata[7:0] == accumulator)
        else $error("accumulator read differs from port");
    a_unmapped_zero: assert property (
        read && waitrequest && address == 8'h40 |=> readdata == 32'h0)
        else $error("unmapped read not zero");
    c_mul: cover property (start && writedata[7:0] == aid_pkg::OPC_MUL);
    c_div: cover property (start && writedata[7:0] == aid_pkg::OPC_DIV);
    c_refused: cover property (busy && write && waitrequest
        && address == aid_pkg::INSTR_CTRL_OFS);
endmodule // aid_core_properties

// file: testbench/aid_mem_model.sv
// operand memory seen through the fetch path
// assumes the bench holds the address steady before reading
`timescale 1ns/100ps
module aid_mem_model (
    input wire logic [7:0] ram_addr,
    output logic [7:0] ram_data
);
    logic [7:0] ram [256];
    initial begin
        for (int i = 0; i < 256; i++) begin
            ram[i] = 8'(i * 37 + 11);
        end
    end
    assign ram_data = ram[ram_addr];
endmodule // aid_mem_model

// file: testbench/testbench.sv
// self-checking bench for the arithmetic decode unit
// assumes design, memory model and checker compiled first
`timescale 1ns/100ps
module testbench;
    logic clock, rst_b, read, write, waitrequest, busy;
    logic [7:0] address, accumulator, mem_addr, mem_data;
    logic [31:0] writedata, readdata, rd;
    logic [3:0] fams [3];
    int miscompares, check_count;
    aid_core #(.MC_CLKS(2)) dut (.clock(clock), .rst_b(rst_b),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .busy(busy), .accumulator(accumulator));
    aid_mem_model mem (.ram_addr(mem_addr), .ram_data(mem_data));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ******
    // avalon master: hold until waitrequest samples low
    // ******
    task automatic bus(input logic wr, input logic [7:0] a, d);
        int n;
        @(posedge clock);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= {24'h000000, d};
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (!waitrequest) break;
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n == 50) begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (!busy) break;
        end
        if (n == 100) begin
            miscompares++;
            summarize();
        end
    endtask
    // ******
    // one instruction against the integer model
    // ******
    task automatic run_op(input logic [7:0] opc, a, b, v, input logic cy,
                          input logic dbl);
        logic [7:0] op, ea, eb;
        int s, sv, sg, c, ecy, eov, cyc, len;
        op = v;
        ea = a;
        eb = b;
        cyc = 1;
        len = 1;
        mem_addr = v;
        bus(1, aid_pkg::PRIMARY_OPERAND_REG_OFS, a);
        bus(1, aid_pkg::SECONDARY_OPERAND_REG_OFS, b);
        bus(1, aid_pkg::PROGRAM_FLAGS_WORD_OFS,
            {cy, 2'b00, 2'($urandom), 3'b000});
        if (opc == aid_pkg::OPC_MUL || opc == aid_pkg::OPC_DIV) begin
            cyc = 4;
            ecy = 0;
            eov = 0;
            s = int'(a) * int'(b);
            if (opc == aid_pkg::OPC_MUL) begin
                ea = 8'(s);
                eb = 8'(s >> 8);
                eov = s > 255;
            end else if (b != 8'h00) begin
                ea = a / b;
                eb = a % b;
            end else begin
                ecy = -1;
                eov = 1;
            end
        end else begin
            if (opc[3]) begin
                bus(1, 8'(aid_pkg::BANK_REGS_OFS + 4 * opc[2:0]), v);
            end else if (opc[3:1] == 3'b011) begin
                bus(1, 8'(aid_pkg::BANK_REGS_OFS + 4 * opc[0]), v);
                op = mem_data;
            end else begin
                len = 2;
                bus(1, aid_pkg::BYTE_TWO_OFS, v);
                if (opc[3:0] == aid_pkg::LO_DIR) op = mem_data;
            end
            bus(1, aid_pkg::OPERAND_DATA_OFS, op);
            sg = (opc[7:4] == aid_pkg::FAM_SUBTRACT_WITH_BORROW) ? -1 : 1;
            c = (opc[7:4] == aid_pkg::FAM_ADD) ? 0 : int'(cy);
            s = int'(a) + sg * (int'(op) + c);
            sv = int'($signed(a)) + sg * (int'($signed(op)) + c);
            ecy = s < 0 || s > 255;
            eov = sv < -128 || sv > 127;
            ea = 8'(s);
        end
        bus(1, aid_pkg::INSTR_CTRL_OFS, opc);
        if (dbl) bus(1, aid_pkg::INSTR_CTRL_OFS, 8'h24);
        wait_idle();
        bus(0, aid_pkg::PRIMARY_OPERAND_REG_OFS, 8'h00);
        chk8("acc", ea, rd[7:0]);
        chk8("acc port", ea, accumulator);
        bus(0, aid_pkg::SECONDARY_OPERAND_REG_OFS, 8'h00);
        chk8("b reg", eb, rd[7:0]);
        bus(0, aid_pkg::PROGRAM_FLAGS_WORD_OFS, 8'h00);
        if (ecy >= 0) chk8("cy", 8'(ecy), {7'h00, rd[7]});
        chk8("ov", 8'(eov), {7'h00, rd[2]});
        chk8("parity", {7'h00, ^ea}, {7'h00, rd[0]});
        bus(0, aid_pkg::DECODE_INFO_OFS, 8'h00);
        chk8("cycles", 8'(cyc), {5'h00, rd[5:3]});
        chk8("length", 8'(len), {6'h00, rd[1:0]});
    endtask
    initial begin
        rst_b = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        mem_addr = 8'h00;
        miscompares = 0;
        check_count = 0;
        fams = '{aid_pkg::FAM_ADD, aid_pkg::FAM_ADD_WITH_CARRY, aid_pkg::FAM_SUBTRACT_WITH_BORROW};
        void'($urandom(17));
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        bus(0, aid_pkg::PRIMARY_OPERAND_REG_OFS, 8'h00);
        chk8("acc rst", aid_pkg::PRIMARY_OPERAND_REG_RST, rd[7:0]);
        bus(0, aid_pkg::PROGRAM_FLAGS_WORD_OFS, 8'h00);
        chk8("psw rst", aid_pkg::PROGRAM_FLAGS_WORD_RST, rd[7:0]);
        bus(0, aid_pkg::SECONDARY_OPERAND_REG_OFS, 8'h00);
        chk8("b rst", aid_pkg::SECONDARY_OPERAND_REG_RST, rd[7:0]);
        bus(0, 8'h40, 8'h00);
        chk8("unmapped", 8'h00, rd[7:0]);
        $display("test reset done");
        run_op(8'h24, 8'hFF, 8'h00, 8'h01, 1'b0, 1'b0);
        run_op(8'h94, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0);
        foreach (fams[i]) begin
            for (int lo = 4; lo < 16; lo++) begin
                run_op({fams[i], 4'(lo)}, 8'($urandom), 8'h00,
                       8'($urandom), 1'($urandom), 1'b0);
            end
        end
        $display("test arith done");
        run_op(aid_pkg::OPC_MUL, 8'($urandom), 8'($urandom), 8'h00,
               1'b1, 1'b1);
        run_op(aid_pkg::OPC_DIV, 8'($urandom), 8'h07, 8'h00,
               1'b1, 1'b0);
        run_op(aid_pkg::OPC_DIV, 8'h33, 8'h00, 8'h00, 1'b0, 1'b0);
        $display("test mul div done");
        bus(1, aid_pkg::PRIMARY_OPERAND_REG_OFS, 8'h5A);
        bus(1, aid_pkg::INSTR_CTRL_OFS, 8'hA5);
        wait_idle();
        bus(0, aid_pkg::INSTR_STAT_OFS, 8'h00);
        chk8("illegal", 8'h01, {7'h00, rd[2]});
        chk8("acc kept", 8'h5A, accumulator);
        $display("test illegal done");
        summarize();
    end
endmodule // testbench
bind aid_core aid_core_properties #(.MC_CLKS(MC_CLKS)) props (
    .clock(clock), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .busy(busy), .accumulator(accumulator));
